/* mseq_pkg.sv */
// Package for the microcode sequencer: word layout, vectors, opcodes
package mseq_pkg;
  localparam int MSEQ_ADDR_W = 10;
  localparam int MSEQ_WORD_W = 64;
  localparam int MSEQ_DEPTH = 1024;
  localparam int MSEQ_OUT_W = 16;
  localparam int MSEQ_CPU_W = 32;
  localparam logic [9:0] MSEQ_RESET_ADDR = 10'h000;
  localparam logic [9:0] MSEQ_EXT_VEC_BASE = 10'h008;
  localparam logic [9:0] MSEQ_INT_VEC_BASE = 10'h00C;
  localparam logic [2:0] MSEQ_OP_NEXT = 3'h0;
  localparam logic [2:0] MSEQ_OP_JUMP = 3'h1;
  localparam logic [2:0] MSEQ_OP_BR_TRUE = 3'h2;
  localparam logic [2:0] MSEQ_OP_BR_FALSE = 3'h3;
  localparam logic [2:0] MSEQ_OP_CASE = 3'h4;
  localparam logic [2:0] MSEQ_OP_SET_EN = 3'h5;

  // Control field, 16 bits: op, select, target
  typedef struct packed {
    logic [2:0] op;
    logic [2:0] sel;
    logic [9:0] target;
  } mseq_ctrl_t;

  typedef struct packed {
    mseq_ctrl_t ctrl;
    logic [MSEQ_OUT_W-1:0] out_field;
    logic [MSEQ_CPU_W-1:0] cpu_field;
  } mseq_word_t;

  typedef struct packed {
    logic [9:0] pc;
    logic [7:0] irq_en;
    logic [3:0] ext_s1;
    logic [3:0] ext_s2;
    logic [3:0] ext_prev;
    logic [7:0] cond_s1;
    logic [7:0] cond_s2;
    logic [MSEQ_OUT_W-1:0] out_q;
    logic [MSEQ_CPU_W-1:0] cpu_q;
  } mseq_state_t;
endpackage : mseq_pkg

/* mseq_store.sv */
// Microcode store, combinational read
`timescale 1ns/100ps
`default_nettype none
module mseq_store
  import mseq_pkg::*;
(
  input wire logic mclk,
  input wire logic load_en,
  input wire logic [MSEQ_ADDR_W-1:0] load_addr,
  input wire logic [MSEQ_WORD_W-1:0] load_data,
  input wire logic [MSEQ_ADDR_W-1:0] rd_addr,
  output logic [MSEQ_WORD_W-1:0] rd_data
);
  logic [MSEQ_WORD_W-1:0] mem [MSEQ_DEPTH]; // RULE1

  // Load port stands in for programming of the nonvolatile store
  always_ff @(posedge mclk) begin
    if (load_en) begin
      mem[load_addr] <= load_data;
    end
  end

  assign rd_data = mem[rd_addr]; // RULE2
endmodule // mseq_store
`default_nettype wire

/* mseq_top.sv */
// Microcode sequencer with vectored interrupts and condition branching
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// [RULE1] Store of 1K words, 64 bits each
// [RULE2] One word fetched and executed per clock
// [RULE3] Reset starts execution at address zero
// [RULE4] Word splits into control, output, CPU fields
// [RULE5] All three fields act in same cycle
// [RULE6] Eight interrupts, each gated by enable bit
// [RULE7] External interrupts recognised on rising edge
// [RULE8] External sources vector to 008H through 00BH
// [RULE9] Internal sources vector to 00CH through 00FH
// [RULE10] Any single condition input selects branch
// [RULE11] Four case groups: low, high, two flags
// [RULE12] Group case gives sixteen-way branch
// [RULE13] Pending interrupt overrides; lowest number first
// [RULE14] Otherwise next address from control field
module mseq_top
  import mseq_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [3:0] ext_irq,
  input wire logic internal_irq_a,
  input wire logic internal_irq_b,
  input wire logic internal_irq_c,
  input wire logic internal_irq_d,
  input wire logic [7:0] condition_inputs,
  input wire logic [3:0] flag_group_a,
  input wire logic [3:0] flag_group_b,
  input wire logic load_en,
  input wire logic [MSEQ_ADDR_W-1:0] load_addr,
  input wire logic [MSEQ_WORD_W-1:0] load_data,
  output logic [MSEQ_ADDR_W-1:0] pc,
  output logic [MSEQ_OUT_W-1:0] out_field,
  output logic [MSEQ_CPU_W-1:0] cpu_field,
  output logic irq_taken
);
  mseq_state_t st, next_st;
  logic [MSEQ_WORD_W-1:0] word_raw;
  mseq_word_t word;
  logic [3:0] ext_rise;
  logic [7:0] pending;
  logic [3:0] case_group_low, case_group_high, case_sel;
  logic cond_bit;
  logic [9:0] seq_addr;
  logic [2:0] irq_num;
  logic irq_any;

  mseq_store u_store (
    .mclk(mclk),
    .load_en(load_en),
    .load_addr(load_addr),
    .load_data(load_data),
    .rd_addr(st.pc),
    .rd_data(word_raw)
  );

  assign word = mseq_word_t'(word_raw); // RULE4
  assign case_group_low = st.cond_s2[3:0]; // RULE11
  assign case_group_high = st.cond_s2[7:4]; // RULE11
  assign ext_rise = st.ext_s2 & ~st.ext_prev; // RULE7
  // Internal sources come from on-chip logic, so they are not synchronised
  assign pending = {internal_irq_d, internal_irq_c, internal_irq_b, internal_irq_a, ext_rise}
                   & st.irq_en; // RULE6

  always_comb begin
    irq_any = 1'b0;
    irq_num = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (pending[i]) begin
        irq_any = 1'b1;
        irq_num = 3'(i); // RULE13
      end
    end
  end

  always_comb begin
    cond_bit = st.cond_s2[word.ctrl.sel]; // RULE10
    case (word.ctrl.sel[1:0])
      2'h0: case_sel = case_group_low;
      2'h1: case_sel = case_group_high;
      2'h2: case_sel = flag_group_a;
      default: case_sel = flag_group_b;
    endcase
    case (word.ctrl.op)
      MSEQ_OP_NEXT: seq_addr = st.pc + 10'h001; // RULE14
      MSEQ_OP_JUMP: seq_addr = word.ctrl.target;
      MSEQ_OP_BR_TRUE: seq_addr = cond_bit ? word.ctrl.target : st.pc + 10'h001; // RULE10
      MSEQ_OP_BR_FALSE: seq_addr = cond_bit ? st.pc + 10'h001 : word.ctrl.target;
      MSEQ_OP_CASE: seq_addr = {word.ctrl.target[9:4], case_sel}; // RULE12
      MSEQ_OP_SET_EN: seq_addr = st.pc + 10'h001;
      default: seq_addr = st.pc + 10'h001;
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.ext_s1 = ext_irq;
    next_st.ext_s2 = st.ext_s1;
    next_st.ext_prev = st.ext_s2;
    next_st.cond_s1 = condition_inputs;
    next_st.cond_s2 = st.cond_s1;
    next_st.out_q = word.out_field; // RULE5
    next_st.cpu_q = word.cpu_field; // RULE5
    // Enables load from the target field's low byte
    if (word.ctrl.op == MSEQ_OP_SET_EN) begin
      next_st.irq_en = word.ctrl.target[7:0]; // RULE6
    end
    if (irq_any) begin
      if (irq_num[2]) begin
        next_st.pc = MSEQ_INT_VEC_BASE + {8'h00, irq_num[1:0]}; // RULE9
      end else begin
        next_st.pc = MSEQ_EXT_VEC_BASE + {8'h00, irq_num[1:0]}; // RULE8
      end
    end else begin
      next_st.pc = seq_addr; // RULE14
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0; // RULE3
    end else begin
      st <= next_st; // RULE2
    end
  end

  assign pc = st.pc;
  assign out_field = st.out_q;
  assign cpu_field = st.cpu_q;
  assign irq_taken = irq_any;

  // Reset release and synchronised pin rise are named once, each used by one assertion below
  sequence s_reset_release;
    !arst_n ##1 arst_n;
  endsequence

  sequence s_pin_rose;
    (st.ext_s1 & ~st.ext_s2) != 4'h0;
  endsequence

  a_reset_pc: assert property (@(posedge mclk) !arst_n |=> pc == MSEQ_RESET_ADDR) // RULE3
    else $error("pc not zero after reset");

  a_first_word: assert property (@(posedge mclk) // RULE3
    s_reset_release |-> pc == MSEQ_RESET_ADDR && !irq_any)
    else $error("first word after reset not at zero");

  a_ext_vector: assert property (@(posedge mclk) disable iff (!arst_n) // RULE8
    irq_any && !irq_num[2] |=> pc == MSEQ_EXT_VEC_BASE + {8'h00, $past(irq_num[1:0])})
    else $error("bad external vector");

  a_int_vector: assert property (@(posedge mclk) disable iff (!arst_n) // RULE9
    irq_any && irq_num[2] |=> pc == MSEQ_INT_VEC_BASE + {8'h00, $past(irq_num[1:0])})
    else $error("bad internal vector");

  a_lowest_first: assert property (@(posedge mclk) disable iff (!arst_n) // RULE13
    pending[0] |=> pc == MSEQ_EXT_VEC_BASE)
    else $error("priority wrong");

  // Checked against a mask so a broken scan order cannot hide
  a_irq_priority: assert property (@(posedge mclk) disable iff (!arst_n) // RULE13
    irq_any |-> pending[irq_num]
    && (pending & ((8'h01 << irq_num) - 8'h01)) == 8'h00)
    else $error("lower interrupt passed over");

  a_seq_follow: assert property (@(posedge mclk) disable iff (!arst_n) // RULE14
    !irq_any |=> pc == $past(seq_addr))
    else $error("pc did not follow control field");

  a_next_step: assert property (@(posedge mclk) disable iff (!arst_n) // RULE14
    !irq_any && word.ctrl.op == MSEQ_OP_NEXT |=> pc == $past(pc) + 10'h001)
    else $error("next op did not step");

  a_jump_target: assert property (@(posedge mclk) disable iff (!arst_n) // RULE14
    !irq_any && word.ctrl.op == MSEQ_OP_JUMP |=> pc == $past(word.ctrl.target))
    else $error("jump missed its target");

  a_fields_par: assert property (@(posedge mclk) disable iff (!arst_n) // RULE5
    1'b1 |=> out_field == $past(word.out_field) && cpu_field == $past(word.cpu_field))
    else $error("fields not issued together");

  // A level held high must not fire twice
  a_edge_only: assert property (@(posedge mclk) disable iff (!arst_n) // RULE7
    (ext_rise & $past(ext_rise)) == 4'h0)
    else $error("level seen as edge");

  a_pin_to_edge: assert property (@(posedge mclk) disable iff (!arst_n) // RULE7
    s_pin_rose |=> ext_rise == $past(st.ext_s1 & ~st.ext_s2))
    else $error("synchronised rise not detected");

  a_masked_irq: assert property (@(posedge mclk) disable iff (!arst_n) // RULE6
    st.irq_en == 8'h00 |-> !irq_any)
    else $error("masked interrupt taken");

  a_en_load: assert property (@(posedge mclk) disable iff (!arst_n) // RULE6
    word.ctrl.op == MSEQ_OP_SET_EN |=> st.irq_en == $past(word.ctrl.target[7:0]))
    else $error("enables not loaded");

  a_case_branch: assert property (@(posedge mclk) disable iff (!arst_n) // RULE12
    !irq_any && word.ctrl.op == MSEQ_OP_CASE && word.ctrl.sel[1:0] == 2'h0
    |=> pc[3:0] == $past(case_group_low))
    else $error("case branch wrong");

  a_case_high: assert property (@(posedge mclk) disable iff (!arst_n) // RULE12
    !irq_any && word.ctrl.op == MSEQ_OP_CASE && word.ctrl.sel[1:0] == 2'h1
    |=> pc == {$past(word.ctrl.target[9:4]), $past(case_group_high)})
    else $error("high case branch wrong");

  a_case_flag_a: assert property (@(posedge mclk) disable iff (!arst_n) // RULE11
    !irq_any && word.ctrl.op == MSEQ_OP_CASE && word.ctrl.sel[1:0] == 2'h2
    |=> pc[3:0] == $past(flag_group_a))
    else $error("first flag group case wrong");

  a_case_flag_b: assert property (@(posedge mclk) disable iff (!arst_n) // RULE11
    !irq_any && word.ctrl.op == MSEQ_OP_CASE && word.ctrl.sel[1:0] == 2'h3
    |=> pc[3:0] == $past(flag_group_b))
    else $error("second flag group case wrong");

  a_cond_true: assert property (@(posedge mclk) disable iff (!arst_n) // RULE10
    !irq_any && word.ctrl.op == MSEQ_OP_BR_TRUE && cond_bit
    |=> pc == $past(word.ctrl.target))
    else $error("condition branch missed");

  a_cond_false: assert property (@(posedge mclk) disable iff (!arst_n) // RULE10
    !irq_any && word.ctrl.op == MSEQ_OP_BR_FALSE && !cond_bit
    |=> pc == $past(word.ctrl.target))
    else $error("false condition branch missed");
endmodule // mseq_top
`default_nettype wire

/* mseq_ext_drv.sv */
// Far-side logic model that raises external interrupt pins
`timescale 1ns/100ps
`default_nettype none
module mseq_ext_drv
  import mseq_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [3:0] req,
  output logic [3:0] ext_irq
);
  logic [3:0][2:0] hold;
  // Pin held high several cycles so the two-stage synchroniser cannot miss it
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ext_irq <= 4'h0;
      hold <= '0;
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (req[k]) begin
          ext_irq[k] <= 1'b1;
          hold[k] <= 3'h4;
        end else if (hold[k] != 3'h0) begin
          hold[k] <= hold[k] - 3'h1;
        end else begin
          ext_irq[k] <= 1'b0;
        end
      end
    end
  end
endmodule // mseq_ext_drv
`default_nettype wire

/* tb.sv */
// Self-checking testbench for the microcode sequencer
`timescale 1ns/100ps
`default_nettype none
module tb;
  import mseq_pkg::*;
  typedef struct packed {
    logic [9:0] a;
    logic [2:0] op;
    logic [2:0] sel;
    logic [9:0] t;
    logic [9:0] n;
  } mseq_row_t;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] req = 4'h0;
  logic [3:0] ext_irq;
  logic internal_irq_a = 1'b0;
  logic internal_irq_b = 1'b0;
  logic internal_irq_c = 1'b0;
  logic internal_irq_d = 1'b0;
  logic [7:0] condition_inputs = 8'hA5;
  logic [3:0] flag_group_a = 4'h3;
  logic [3:0] flag_group_b = 4'hC;
  logic load_en = 1'b0;
  logic [9:0] load_addr = 10'h000;
  logic [63:0] load_data = 64'h0;
  logic [9:0] pc;
  logic [15:0] out_field;
  logic [31:0] cpu_field;
  logic irq_taken;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  // Rows 11 to 13 are vector words, reached through interrupts; row 12 is also reached by stepping from row 11
  mseq_row_t rows [14] = '{
    '{10'h000, MSEQ_OP_BR_TRUE, 3'h1, 10'h3FF, 10'h001},
    '{10'h001, MSEQ_OP_NEXT, 3'h0, 10'h000, 10'h002},
    '{10'h002, MSEQ_OP_JUMP, 3'h0, 10'h040, 10'h040},
    '{10'h040, MSEQ_OP_BR_TRUE, 3'h0, 10'h050, 10'h050},
    '{10'h050, MSEQ_OP_BR_FALSE, 3'h1, 10'h060, 10'h060},
    '{10'h060, MSEQ_OP_CASE, 3'h0, 10'h080, 10'h085},
    '{10'h085, MSEQ_OP_CASE, 3'h1, 10'h090, 10'h09A},
    '{10'h09A, MSEQ_OP_CASE, 3'h2, 10'h0A0, 10'h0A3},
    '{10'h0A3, MSEQ_OP_CASE, 3'h3, 10'h0B0, 10'h0BC},
    '{10'h0BC, MSEQ_OP_SET_EN, 3'h0, 10'h0FF, 10'h0BD},
    '{10'h0BD, MSEQ_OP_JUMP, 3'h0, 10'h0BD, 10'h0BD},
    '{10'h00B, MSEQ_OP_SET_EN, 3'h0, 10'h000, 10'h00C},
    '{10'h00C, MSEQ_OP_JUMP, 3'h0, 10'h0BD, 10'h0BD},
    '{10'h008, MSEQ_OP_JUMP, 3'h0, 10'h0BD, 10'h0BD}};
  mseq_top mseq_top_i (.mclk, .arst_n, .ext_irq, .internal_irq_a, .internal_irq_b,
    .internal_irq_c, .internal_irq_d, .condition_inputs, .flag_group_a, .flag_group_b,
    .load_en, .load_addr, .load_data, .pc, .out_field, .cpu_field, .irq_taken);
  mseq_ext_drv mseq_ext_drv_i (.mclk, .arst_n, .req, .ext_irq);
  always #5 mclk = ~mclk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    if (num_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Ceiling well above the fewer than a hundred cycles the sequence needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 1000) begin
      num_errors++;
      conclude;
    end
  end
  initial begin
    for (int i = 0; i < 14; i++) begin
      @(negedge mclk);
      load_en = 1'b1;
      load_addr = rows[i].a;
      load_data = {rows[i].op, rows[i].sel, rows[i].t, 6'h3F, rows[i].a, 22'h0, rows[i].a};
    end
    @(negedge mclk);
    load_en = 1'b0;
    check(pc, MSEQ_RESET_ADDR);
    arst_n = 1'b1;
    for (int i = 0; i < 11; i++) begin
      check(pc, rows[i].a);
      @(negedge mclk);
      check(out_field, {6'h3F, rows[i].a});
      check(cpu_field, {22'h0, rows[i].a});
      check(pc, rows[i].n);
      check(irq_taken, 1'b0);
    end
    internal_irq_a = 1'b1;
    internal_irq_b = 1'b1;
    #1 check(irq_taken, 1'b1);
    @(negedge mclk);
    check(pc, MSEQ_INT_VEC_BASE);
    internal_irq_a = 1'b0;
    internal_irq_b = 1'b0;
    @(negedge mclk);
    check(pc, 10'h0BD);
    req = 4'h8;
    @(negedge mclk);
    req = 4'h0;
    for (int k = 0; k < 8 && irq_taken !== 1'b1; k++) @(negedge mclk);
    check(irq_taken, 1'b1);
    @(negedge mclk);
    check(pc, MSEQ_EXT_VEC_BASE + 10'h3);
    @(negedge mclk);
    check(pc, 10'h00C);
    internal_irq_d = 1'b1;
    repeat (3) begin
      @(negedge mclk);
      check(pc, 10'h0BD);
      check(irq_taken, 1'b0);
    end
    internal_irq_d = 1'b0;
    arst_n = 1'b0;
    #1 check(pc, MSEQ_RESET_ADDR);
    check(out_field, 16'h0);
    @(negedge mclk);
    arst_n = 1'b1;
    @(negedge mclk);
    check(pc, 10'h001);
    for (int k = 0; k < 20 && pc !== 10'h0BD; k++) @(negedge mclk);
    check(pc, 10'h0BD);
    req = 4'h1;
    @(negedge mclk);
    req = 4'h0;
    repeat (2) @(negedge mclk);
    check(irq_taken, 1'b1);
    internal_irq_c = 1'b1;
    @(negedge mclk);
    check(pc, MSEQ_EXT_VEC_BASE);
    internal_irq_c = 1'b0;
    @(negedge mclk);
    check(pc, 10'h0BD);
    conclude;
  end
endmodule // tb
`default_nettype wire
